// ===== hdl/mrmf_pkg.sv
/*
 * shared constants for the serial master framer: function codes,
 * frame layout, crc figures, silence timing and result codes.
 * assumes a 10 MHz system clock and a byte-wide uart layer outside the block.
 */
package mrmf_pkg;

    // clock and line timing
    localparam int unsigned CLK_HZ         = 10_000_000;
    localparam int unsigned BAUD           = 9_600;
    localparam int unsigned BITS_PER_CHAR  = 11;
    // silence of three and a half characters, in tenths of a character
    localparam int unsigned SILENCE_TENTHS = 35;
    localparam int unsigned SILENCE_CYC    =
        (CLK_HZ * BITS_PER_CHAR * SILENCE_TENTHS + BAUD * 10 - 1) / (BAUD * 10);

    // station address limits
    localparam logic [7:0] ADDR_BCAST = 8'h00;
    localparam logic [7:0] ADDR_MAX   = 8'hF7;

    // function codes
    localparam logic [7:0] FC_RD_COILS  = 8'h01;
    localparam logic [7:0] FC_RD_DISC   = 8'h02;
    localparam logic [7:0] FC_RD_HOLD   = 8'h03;
    localparam logic [7:0] FC_RD_INREG  = 8'h04;
    localparam logic [7:0] FC_WR_COIL   = 8'h05;
    localparam logic [7:0] FC_WR_REG    = 8'h06;
    localparam logic [7:0] FC_WR_COILS  = 8'h0F;
    localparam logic [7:0] FC_WR_REGS   = 8'h10;
    localparam int unsigned FC_ERR_BIT  = 7;

    // crc
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;

    // frame sizes
    localparam int unsigned HDR_BYTES  = 6;
    localparam int unsigned PAY_WORDS  = 8;
    localparam int unsigned RX_MAX     = 32;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned FIFO_WIDTH = 8;

    // result codes
    localparam logic [1:0] RES_OK     = 2'h0;
    localparam logic [1:0] RES_EXCEPT = 2'h1;
    localparam logic [1:0] RES_BADCMD = 2'h2;
    localparam logic [1:0] RES_MISM   = 2'h3;

endpackage

// ===== hdl/mrmf_byte_if.sv
/*
 * valid/ready byte stream between the framer and its fifo.
 * assumes one clock for both ends.
 */
`timescale 1ns/100ps
`default_nettype none
interface mrmf_byte_if;
    logic       valid;
    logic       ready;
    logic [7:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== hdl/mrmf_fifo.sv
/*
 * flip-flop fifo with valid/ready on both sides, honest full and empty.
 * assumes a single clock and asynchronous active-low reset.
 */
`timescale 1ns/100ps
`default_nettype none
module mrmf_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    // handshakes
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // storage
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= wr_q + AW'(1);
            end
            if (pop)
            begin
                rd_q <= rd_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ===== hdl/mrmf_framer.sv
/*
 * serial master framer: builds queries from a command, sends them through a
 * 16-byte fifo to the uart, then parses the slave reply until line silence.
 * assumes an outside uart that takes tx bytes on valid/ready and gives rx
 * bytes as single-cycle strobes from another domain (synchronised here).
 */
`timescale 1ns/100ps
`default_nettype none
module mrmf_framer (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // command
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic [7:0]  cmd_station_address,
    input  wire logic [7:0]  cmd_func,
    input  wire logic [15:0] cmd_ref,
    input  wire logic [15:0] cmd_count,
    input  wire logic [3:0]  cmd_words,
    input  wire logic        cmd_swap32,
    input  wire logic [127:0] cmd_payload,
    // uart transmit
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic [7:0]       tx_data,
    // uart receive
    input  wire logic        rx_strobe,
    input  wire logic [7:0]  rx_byte,
    // result
    output logic             res_valid,
    output logic [1:0]       res_code,
    output logic [7:0]       res_exc,
    output logic [7:0]       res_len,
    output logic [7:0]       res_data0,
    output logic [7:0]       res_data1
);
    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_SEND = 5'b00010,
        S_WAIT = 5'b00100,
        S_RECV = 5'b01000,
        S_DONE = 5'b10000
    } mrmf_state_t;

    // crc step over one byte
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++)
        begin
            r = r[0] ? ((r >> 1) ^ mrmf_pkg::CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // function code in the supported set of eight codes, reads and writes alike
    function automatic logic fc_ok(input logic [7:0] f);
        case (f)
            mrmf_pkg::FC_RD_COILS, mrmf_pkg::FC_RD_DISC,
            mrmf_pkg::FC_RD_HOLD,  mrmf_pkg::FC_RD_INREG,
            mrmf_pkg::FC_WR_COIL,  mrmf_pkg::FC_WR_REG,
            mrmf_pkg::FC_WR_COILS, mrmf_pkg::FC_WR_REGS: fc_ok = 1'b1;
            default:                                     fc_ok = 1'b0;
        endcase
    endfunction

    // function codes whose query carries words after the header
    function automatic logic fc_multi(input logic [7:0] f);
        fc_multi = (f == mrmf_pkg::FC_WR_COILS) || (f == mrmf_pkg::FC_WR_REGS);
    endfunction

    mrmf_state_t  st_q;
    logic [7:0]   qbuf_q [mrmf_pkg::HDR_BYTES + 1 + 2*mrmf_pkg::PAY_WORDS + 2];
    logic [5:0]   qlen_q;
    logic [5:0]   qidx_q;
    logic [15:0]  tx_crc_q;
    logic         bcast_q;
    logic [7:0]   qfunc_q;
    logic [15:0]  rx_crc_q;
    logic [7:0]   rx_cnt_q;
    logic [7:0]   rx_b1_q;
    logic [7:0]   rx_b2_q;
    logic [7:0]   rx_b3_q;
    logic [7:0]   rx_b4_q;
    logic [23:0]  sil_q;
    logic         rs1_q;
    logic         rs2_q;
    logic         rs3_q;
    logic [7:0]   rd1_q;
    logic [7:0]   rd2_q;
    logic         rx_ev;
    logic         cmd_ok;
    logic         cmd_ready_q;
    logic         res_valid_q;
    logic [1:0]   res_code_q;
    logic [7:0]   res_exc_q;
    logic [7:0]   res_len_q;
    logic [7:0]   res_d0_q;
    logic [7:0]   res_d1_q;
    logic [7:0]   nxt_byte;
    logic         crc_phase;
    mrmf_byte_if  fq_in ();

    // receive strobe and byte pass two flops, edge taken after
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
            rs3_q <= 1'b0;
            rd1_q <= 8'h00;
            rd2_q <= 8'h00;
        end
        else
        begin
            rs1_q <= rx_strobe;
            rs2_q <= rs1_q;
            rs3_q <= rs2_q;
            rd1_q <= rx_byte;
            rd2_q <= rd1_q;
        end
    end
    assign rx_ev = rs2_q & ~rs3_q;

    // command check: address range, function set
    assign cmd_ok = (cmd_station_address <= mrmf_pkg::ADDR_MAX)
                  && fc_ok(cmd_func);

    // next byte to push: stored byte, then crc low and high
    assign crc_phase = (qidx_q >= qlen_q);
    assign nxt_byte  = !crc_phase ? qbuf_q[qidx_q[4:0]]
                     : (qidx_q == qlen_q) ? tx_crc_q[7:0] : tx_crc_q[15:8];
    assign fq_in.valid = (st_q == S_SEND);
    assign fq_in.data  = nxt_byte;

    // query assembly buffer
    always_ff @(posedge clk)
    begin
        if (st_q == S_IDLE && cmd_valid && cmd_ok)
        begin
            qbuf_q[0] <= cmd_station_address;
            qbuf_q[1] <= cmd_func;
            qbuf_q[2] <= cmd_ref[15:8];
            qbuf_q[3] <= cmd_ref[7:0];
            qbuf_q[4] <= cmd_count[15:8];
            qbuf_q[5] <= cmd_count[7:0];
            qbuf_q[6] <= {3'b000, cmd_words, 1'b0};
            for (int w = 0; w < mrmf_pkg::PAY_WORDS; w++)
            begin
                // pairs swapped so the more significant word of each pair leaves first
                automatic int src = (cmd_swap32) ? (w ^ 1) : w;
                qbuf_q[7+2*w] <= cmd_payload[16*src+8 +: 8];
                qbuf_q[8+2*w] <= cmd_payload[16*src   +: 8];
            end
        end
    end

    // main sequencing
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q     <= S_IDLE;
            qlen_q   <= 6'd0;
            qidx_q   <= 6'd0;
            tx_crc_q <= mrmf_pkg::CRC_INIT;
            bcast_q  <= 1'b0;
            qfunc_q  <= 8'h00;
        end
        else
        begin
            case (st_q)
                S_IDLE:
                begin
                    // only a command starts bus traffic
                    if (cmd_valid && cmd_ok)
                    begin
                        st_q     <= S_SEND;
                        qidx_q   <= 6'd0;
                        tx_crc_q <= mrmf_pkg::CRC_INIT;
                        bcast_q  <= (cmd_station_address == mrmf_pkg::ADDR_BCAST);
                        qfunc_q  <= cmd_func;
                        if (fc_multi(cmd_func))
                        begin
                            qlen_q <= 6'(mrmf_pkg::HDR_BYTES + 1) + {1'b0, cmd_words, 1'b0};
                        end
                        else
                        begin
                            qlen_q <= 6'(mrmf_pkg::HDR_BYTES);
                        end
                    end
                end
                S_SEND:
                begin
                    if (fq_in.ready)
                    begin
                        if (!crc_phase)
                        begin
                            tx_crc_q <= crc_byte(tx_crc_q, nxt_byte);
                        end
                        qidx_q <= qidx_q + 6'd1;
                        if (qidx_q == qlen_q + 6'd1)
                        begin
                            st_q <= bcast_q ? S_DONE : S_WAIT;
                        end
                    end
                end
                S_WAIT:
                begin
                    if (rx_ev)
                    begin
                        st_q <= S_RECV;
                    end
                end
                S_RECV:
                begin
                    if (sil_q == 24'(mrmf_pkg::SILENCE_CYC))
                    begin
                        st_q <= S_DONE;
                    end
                end
                S_DONE:  st_q <= S_IDLE;
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // reply capture and silence counter
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_crc_q <= mrmf_pkg::CRC_INIT;
            rx_cnt_q <= 8'h00;
            rx_b1_q  <= 8'h00;
            rx_b2_q  <= 8'h00;
            rx_b3_q  <= 8'h00;
            rx_b4_q  <= 8'h00;
            sil_q    <= 24'h00_0000;
        end
        else if (st_q == S_WAIT || st_q == S_RECV)
        begin
            if (rx_ev)
            begin
                rx_crc_q <= crc_byte(rx_crc_q, rd2_q);
                rx_cnt_q <= rx_cnt_q + 8'h01;
                sil_q    <= 24'h00_0000;
                case (rx_cnt_q)
                    8'h01:   rx_b1_q <= rd2_q;
                    8'h02:   rx_b2_q <= rd2_q;
                    8'h03:   rx_b3_q <= rd2_q;
                    8'h04:   rx_b4_q <= rd2_q;
                    default: ;
                endcase
            end
            else if (st_q == S_RECV)
            begin
                sil_q <= sil_q + 24'h00_0001;
            end
        end
        else
        begin
            rx_crc_q <= mrmf_pkg::CRC_INIT;
            rx_cnt_q <= 8'h00;
            sil_q    <= 24'h00_0000;
        end
    end

    // result and command-ready outputs
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cmd_ready_q <= 1'b0;
            res_valid_q <= 1'b0;
            res_code_q  <= mrmf_pkg::RES_OK;
            res_exc_q   <= 8'h00;
            res_len_q   <= 8'h00;
            res_d0_q    <= 8'h00;
            res_d1_q    <= 8'h00;
        end
        else
        begin
            cmd_ready_q <= (st_q == S_IDLE) && !cmd_valid;
            res_valid_q <= 1'b0;
            if (st_q == S_IDLE && cmd_valid && !cmd_ok)
            begin
                res_valid_q <= 1'b1;
                res_code_q  <= mrmf_pkg::RES_BADCMD;
                res_len_q   <= 8'h00;
            end
            else if (st_q == S_SEND && bcast_q && fq_in.ready && qidx_q == qlen_q + 6'd1)
            begin
                res_valid_q <= 1'b1;
                res_code_q  <= mrmf_pkg::RES_OK;
                res_len_q   <= 8'h00;
            end
            else if (st_q == S_RECV && sil_q == 24'(mrmf_pkg::SILENCE_CYC))
            begin
                // good crc leaves residue zero; failing frames are dropped
                if (rx_crc_q == 16'h0000 && rx_cnt_q >= 8'h05)
                begin
                    res_valid_q <= 1'b1;
                    res_len_q   <= rx_cnt_q - 8'h02;
                    res_exc_q   <= rx_b2_q;
                    res_d0_q    <= rx_b3_q;
                    res_d1_q    <= rx_b4_q;
                    if (rx_b1_q[mrmf_pkg::FC_ERR_BIT])
                    begin
                        res_code_q <= mrmf_pkg::RES_EXCEPT;
                    end
                    else if (rx_b1_q != qfunc_q)
                    begin
                        res_code_q <= mrmf_pkg::RES_MISM;
                    end
                    else
                    begin
                        res_code_q <= mrmf_pkg::RES_OK;
                    end
                end
            end
        end
    end

    assign cmd_ready = cmd_ready_q;
    assign res_valid = res_valid_q;
    assign res_code  = res_code_q;
    assign res_exc   = res_exc_q;
    assign res_len   = res_len_q;
    assign res_data0 = res_d0_q;
    assign res_data1 = res_d1_q;

    // outgoing byte fifo, drained by the uart
    mrmf_fifo #(
        .WIDTH (mrmf_pkg::FIFO_WIDTH),
        .DEPTH (mrmf_pkg::FIFO_DEPTH)
    ) u_txq (
        .clk       (clk),
        .arst_n    (arst_n),
        .in_valid  (fq_in.valid),
        .in_ready  (fq_in.ready),
        .in_data   (fq_in.data),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  (tx_data)
    );
endmodule
`default_nettype wire

// ===== verif/mrmf_slave_model.sv
/* slave model for the framer: takes query bytes with stalls and answers
   an eight-byte unicast query with an exception reply after silence.
   assumes query bytes leave the framer on tx valid/ready. */
`timescale 1ns/100ps
`default_nettype none
module mrmf_slave_model #(
    parameter logic [7:0] EXC = 8'h02
) (
    // clock, reset, test control
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       stall,
    // query side
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic [7:0] tx_data,
    // reply side
    output logic            rx_strobe,
    output logic [7:0]      rx_byte
);
    logic [7:0]  q[$];
    logic [7:0]  r[$];
    logic [15:0] c;
    logic [1:0]  ph;
    int          idle;

    // reflected crc over a byte queue
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] s;
        s = mrmf_pkg::CRC_INIT;
        foreach (b[i])
        begin
            s = s ^ {8'h00, b[i]};
            repeat (8) s = s[0] ? (s >> 1) ^ mrmf_pkg::CRC_POLY : s >> 1;
        end
        return s;
    endfunction

    // one byte: strobe high four edges, low four, byte released late
    task automatic put(input logic [7:0] b);
        rx_byte <= b;
        rx_strobe <= 1'b1;
        repeat (4) @(posedge clk);
        rx_strobe <= 1'b0;
        repeat (2) @(posedge clk);
        rx_byte <= ~b;
        repeat (2) @(posedge clk);
    endtask

    // take query bytes, stall one cycle in four, answer after silence
    initial
    begin
        tx_ready = 1'b0;
        rx_strobe = 1'b0;
        rx_byte = 8'h00;
        ph = 2'h0;
        idle = 0;
        forever
        begin
            @(posedge clk);
            ph = ph + 2'h1;
            if (arst_n !== 1'b1)
                q.delete();
            else if (tx_valid === 1'b1 && tx_ready === 1'b1)
                q.push_back(tx_data);
            idle = (tx_valid === 1'b1 && tx_ready === 1'b1) ? 0 : idle + 1;
            tx_ready <= arst_n && !stall && ph != 2'h3;
            if (idle == 50 && q.size() == 8 && q[0] != 8'h00)
            begin
                r = {q[0], q[1] | 8'h80, EXC};
                c = crc16(r);
                r.push_back(c[7:0]);
                r.push_back(c[15:8]);
                foreach (r[i]) put(r[i]);
            end
            if (idle == 50)
                q.delete();
        end
    end
endmodule
`default_nettype wire

// ===== verif/mrmf_framer_monitor.sv
/* checker on the framer top ports: refusals, query head, result pulse.
   assumes it is bound to every framer instance. */
`timescale 1ns/100ps
`default_nettype none
module mrmf_framer_monitor (
    // clock and reset
    input wire logic         clk,
    input wire logic         arst_n,
    // command
    input wire logic         cmd_valid,
    input wire logic         cmd_ready,
    input wire logic [7:0]   cmd_station_address,
    input wire logic [7:0]   cmd_func,
    input wire logic [15:0]  cmd_ref,
    input wire logic [15:0]  cmd_count,
    input wire logic [3:0]   cmd_words,
    input wire logic         cmd_swap32,
    input wire logic [127:0] cmd_payload,
    // uart
    input wire logic         tx_valid,
    input wire logic         tx_ready,
    input wire logic [7:0]   tx_data,
    input wire logic         rx_strobe,
    input wire logic [7:0]   rx_byte,
    // result
    input wire logic         res_valid,
    input wire logic [1:0]   res_code,
    input wire logic [7:0]   res_exc,
    input wire logic [7:0]   res_len,
    input wire logic [7:0]   res_data0,
    input wire logic [7:0]   res_data1
);
    logic        take;
    logic        fc_ok;
    logic        seen_q;
    logic [4:0]  idx_q;
    logic [47:0] hdr_q;

    // command taken, and whether its function is one of the eight
    assign take = cmd_valid && cmd_ready;
    assign fc_ok = cmd_func inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0F, 8'h10};

    // byte index within the frame in flight
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            idx_q <= 5'h00;
        else if (take)
            idx_q <= 5'h00;
        else if (tx_valid && tx_ready)
            idx_q <= idx_q + 5'h01;
    end

    // any command seen since reset
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            seen_q <= 1'b0;
        else if (take)
            seen_q <= 1'b1;
    end

    // header fields of the command taken
    always_ff @(posedge clk)
    begin
        if (take)
            hdr_q <= {cmd_station_address, cmd_func, cmd_ref, cmd_count};
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    sequence beat(int n);
        tx_valid && tx_ready && idx_q == n;
    endsequence
    sequence bcast_take;
        take && fc_ok && cmd_station_address == 8'h00;
    endsequence

    bad_address_a: assert property (take && cmd_station_address > 8'hF7 |=>
        res_valid && res_code == mrmf_pkg::RES_BADCMD) else $error("address not refused");
    bad_function_a: assert property (take && !fc_ok |=>
        res_valid && res_code == mrmf_pkg::RES_BADCMD) else $error("function not refused");
    bcast_done_a: assert property (bcast_take |->
        ##[2:200] res_valid && res_code == mrmf_pkg::RES_OK) else $error("broadcast no result");
    result_pulse_a: assert property (res_valid |=> !res_valid)
        else $error("result pulse too long");
    result_stands_a: assert property (!res_valid |-> $stable(res_code) && $stable(res_exc))
        else $error("result fields moved");
    first_byte_a: assert property (beat(0) |-> tx_data == hdr_q[47:40])
        else $error("first byte not address");
    func_byte_a: assert property (beat(1) |-> tx_data == hdr_q[39:32])
        else $error("second byte not function");
    ref_high_a: assert property (beat(2) |-> tx_data == hdr_q[31:24])
        else $error("reference high byte wrong");
    count_low_a: assert property (beat(5) |-> tx_data == hdr_q[7:0])
        else $error("count low byte wrong");
    no_early_tx_a: assert property (!seen_q |-> !tx_valid)
        else $error("transmit without command");
endmodule
bind mrmf_framer mrmf_framer_monitor mon_u (
    .clk, .arst_n, .cmd_valid, .cmd_ready, .cmd_station_address, .cmd_func,
    .cmd_ref, .cmd_count, .cmd_words, .cmd_swap32, .cmd_payload, .tx_valid,
    .tx_ready, .tx_data, .rx_strobe, .rx_byte, .res_valid, .res_code,
    .res_exc, .res_len, .res_data0, .res_data1
);
`default_nettype wire

// ===== verif/test_modbus_rtu_master_framer.sv
/* bench for the framer: byte model of each query, slave model on the line.
   assumes the package silence figure; one unicast costs about 40k cycles. */
`timescale 1ns/100ps
`default_nettype none
module test_modbus_rtu_master_framer;
    localparam logic [7:0] EXC = 8'h02;
    localparam logic [7:0] FCS [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0F, 8'h10};
    logic         clk, arst_n, stall, cmd_valid, cmd_ready, cmd_swap32;
    logic         tx_valid, tx_ready, rx_strobe, res_valid;
    logic [7:0]   cmd_station_address, cmd_func, tx_data, rx_byte;
    logic [7:0]   res_exc, res_len, got_exc, got_len, res_data0, res_data1, got_d0, got_d1;
    logic [15:0]  cmd_ref, cmd_count, seed;
    logic [3:0]   cmd_words;
    logic [127:0] cmd_payload;
    logic [1:0]   res_code, got_code;
    logic [7:0]   txq[$], exq[$];
    int           n_fail = 0, checks = 0, n_res = 0;

    mrmf_framer dut_u (
        .clk, .arst_n, .cmd_valid, .cmd_ready, .cmd_station_address, .cmd_func,
        .cmd_ref, .cmd_count, .cmd_words, .cmd_swap32, .cmd_payload, .tx_valid,
        .tx_ready, .tx_data, .rx_strobe, .rx_byte, .res_valid, .res_code,
        .res_exc, .res_len, .res_data0, .res_data1
    );
    mrmf_slave_model #(.EXC(EXC)) slave_u (
        .clk, .arst_n, .stall, .tx_valid, .tx_ready, .tx_data, .rx_strobe, .rx_byte
    );

    // 10 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // record line bytes and result pulses
    always @(posedge clk)
    begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1)
            txq.push_back(tx_data);
        if (res_valid === 1'b1)
        begin
            {got_code, got_exc, got_len, n_res} = {res_code, res_exc, res_len, n_res + 1};
            {got_d0, got_d1} = {res_data0, res_data1};
        end
    end

    // lfsr source for header fields and payload
    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction

    task automatic cmp(input logic [7:0] g, e);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("[ERR] %0t byte %h expected %h", $time, g, e);
        end
    endtask

    task automatic cmp_res(input logic [1:0] c, input logic [7:0] x, l, input logic full);
        checks++;
        if (got_code !== c || (full && (got_exc !== x || got_len !== l)))
        begin
            n_fail++;
            $display("[ERR] %0t result %h %h %h", $time, got_code, got_exc, got_len);
        end
    endtask

    // one command; the expected frame is built from its fields
    task automatic run(input logic [7:0] a, f, input logic [3:0] w, input logic sw,
                       input int hold);
        int          n, k, ww;
        logic [15:0] c;
        n = n_res;
        txq.delete();
        {cmd_station_address, cmd_func, cmd_words, cmd_swap32} = {a, f, w, sw};
        cmd_ref = rnd();
        cmd_count = rnd();
        for (k = 0; k < 8; k++) cmd_payload[16*k +: 16] = rnd();
        stall = hold > 0;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        if (hold > 0)
        begin
            repeat (hold) @(negedge clk);
            cmp(8'(txq.size()), 8'h00);
            cmp(8'(tx_valid), 8'h01);
            stall = 1'b0;
        end
        for (k = 0; k < 50000 && n_res == n; k++) @(negedge clk);
        cmp(8'(n_res - n), 8'h01);
        if (a > 8'hF7 || !(f inside {FCS}))
        begin
            cmp_res(2'h2, 8'h00, 8'h00, 1'b0);
            return;
        end
        cmp_res(a == 8'h00 ? 2'h0 : 2'h1, EXC, 8'h03, a != 8'h00);
        // exception reply bytes 3 and 4 are its own check field
        exq = {a, f | 8'h80, EXC};
        c = slave_u.crc16(exq);
        if (a != 8'h00)
        begin
            cmp(got_d0, c[7:0]);
            cmp(got_d1, c[15:8]);
        end
        exq = {a, f, cmd_ref[15:8], cmd_ref[7:0], cmd_count[15:8], cmd_count[7:0]};
        if (f == 8'h0F || f == 8'h10)
        begin
            exq.push_back(8'(2 * w));
            for (k = 0; k < w; k++)
            begin
                ww = sw ? k ^ 1 : k;
                exq.push_back(cmd_payload[16*ww+8 +: 8]);
                exq.push_back(cmd_payload[16*ww +: 8]);
            end
        end
        c = slave_u.crc16(exq);
        exq.push_back(c[7:0]);
        exq.push_back(c[15:8]);
        // long enough for the line to go quiet so the slave forgets this frame
        repeat (80) @(negedge clk);
        cmp(8'(txq.size()), 8'(exq.size()));
        foreach (exq[i]) if (i < txq.size()) cmp(txq[i], exq[i]);
    endtask

    task automatic conclude();
        if (n_fail == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        {arst_n, stall, cmd_valid, cmd_swap32, cmd_words} = '0;
        {cmd_station_address, cmd_func, cmd_ref, cmd_count, cmd_payload} = '0;
        seed = 16'h0061;
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        repeat (3) @(negedge clk);
        foreach (FCS[i]) run(8'h00, FCS[i], 4'h2, FCS[i] == 8'h10, 0);
        run(8'h00, 8'h10, 4'h8, 1'b0, 40);
        run(8'h00, 8'h0F, 4'h0, 1'b0, 0);
        run(8'hF8, 8'h03, 4'h0, 1'b0, 0);
        run(8'h01, 8'h07, 4'h0, 1'b0, 0);
        run(8'h01, 8'h00, 4'h0, 1'b0, 0);
        run(8'hF7, 8'h03, 4'h0, 1'b0, 0);
        conclude();
    end

    // hang guard, generous against the one unicast silence wait
    initial
    begin
        repeat (60000) @(posedge clk);
        n_fail++;
        conclude();
    end
endmodule
`default_nettype wire
